// ==== design/quad_pot_terminal_control.v ====
`include "quad_pot_map.vh"

module quad_pot_terminal_control #(
    parameter       EIGHT_BIT  = 1,
    parameter [9:0] FULL_SCALE = EIGHT_BIT ? `WIPER_FULL_8BIT
                                           : `WIPER_FULL_7BIT,
    parameter       TAPS       = EIGHT_BIT ? 257 : 129
) (
    input  wire              clk_in,
    input  wire              rst_n_in,
    input  wire              cmd_wr_in,
    input  wire [2:0]        cmd_target_in,
    input  wire [9:0]        cmd_data_in,
    input  wire              cmd_done_in,
    input  wire              rd_in,
    input  wire [2:0]        rd_target_in,
    input  wire              write_protect_in,
    input  wire [3:0]        nv_lock_in,
    input  wire [39:0]       nv_wiper_in,
    output reg  [9:0]        rd_data_out,
    output reg               rd_valid_out,
    output reg               ready_out,
    output reg  [3:0]        lock_out,
    output reg  [8:0]        terminal_ctrl_pots_0_1_out,
    output reg  [8:0]        terminal_ctrl_pots_2_3_out,
    output reg  [39:0]       wiper_out,
    output reg  [3:0]        term_a_sw_out,
    output reg  [3:0]        wiper_sw_out,
    output reg  [3:0]        term_b_sw_out,
    output reg  [3:0]        wb_join_out,
    output reg  [4*TAPS-1:0] tap_onehot_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg  [8:0]        terminal_ctrl_pots_0_1_reg;
    reg  [8:0]        terminal_ctrl_pots_2_3_reg;
    reg  [8:0]        terminal_ctrl_pots_0_1_next;
    reg  [8:0]        terminal_ctrl_pots_2_3_next;
    reg  [3:0]        lock_reg;
    reg  [39:0]       wiper_reg;
    reg  [39:0]       wiper_next;
    reg               loaded_reg;
    reg               stage_valid_reg;
    reg  [2:0]        stage_target_reg;
    reg  [9:0]        stage_data_reg;
    reg               stage_valid_next;
    reg  [2:0]        stage_target_next;
    reg  [9:0]        stage_data_next;
    reg  [9:0]        rd_data_next;
    wire [8:0]        merged_0_1;
    wire [8:0]        merged_2_3;
    wire [4*TAPS-1:0] tap_onehot;
    wire              commit;

    // ------------------------------------------------------------
    // Lock-aware merges of the staged value
    // ------------------------------------------------------------
    tcon_lock_merge u_merge_0_1 (
        .old_in     (terminal_ctrl_pots_0_1_reg),
        .new_in     (stage_data_next[8:0]),
        .lock_in    (lock_reg[1:0]),
        .merged_out (merged_0_1)
    );

    tcon_lock_merge u_merge_2_3 (
        .old_in     (terminal_ctrl_pots_2_3_reg),
        .new_in     (stage_data_next[8:0]),
        .lock_in    (lock_reg[3:2]),
        .merged_out (merged_2_3)
    );

    // ------------------------------------------------------------
    // Command staging
    // ------------------------------------------------------------
    // A write in the same cycle as completion is part of that command
    always @* begin
        stage_valid_next  = stage_valid_reg;
        stage_target_next = stage_target_reg;
        stage_data_next   = stage_data_reg;
        if (cmd_wr_in) begin
            stage_valid_next  = 1'b1;
            stage_target_next = cmd_target_in;
            stage_data_next   = cmd_data_in;
        end
    end

    // Nothing commits before locks have been reloaded
    assign commit = cmd_done_in & stage_valid_next & loaded_reg;

    // ------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------
    // Write protect only guards nonvolatile memory, so it is unused here
    always @* begin
        terminal_ctrl_pots_0_1_next = terminal_ctrl_pots_0_1_reg;
        terminal_ctrl_pots_2_3_next = terminal_ctrl_pots_2_3_reg;
        wiper_next                  = wiper_reg;
        if (commit) begin
            case (stage_target_next)
                `TGT_TERM_CTRL_0_1: begin
                    terminal_ctrl_pots_0_1_next = merged_0_1;
                end
                `TGT_TERM_CTRL_2_3: begin
                    terminal_ctrl_pots_2_3_next = merged_2_3;
                end
                `TGT_WIPER0: begin
                    if (!lock_reg[0])
                        wiper_next[9:0] = stage_data_next;
                end
                `TGT_WIPER1: begin
                    if (!lock_reg[1])
                        wiper_next[19:10] = stage_data_next;
                end
                `TGT_WIPER2: begin
                    if (!lock_reg[2])
                        wiper_next[29:20] = stage_data_next;
                end
                `TGT_WIPER3: begin
                    if (!lock_reg[3])
                        wiper_next[39:30] = stage_data_next;
                end
                default: begin
                    wiper_next = wiper_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command stage register
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_valid_reg  <= 1'b0;
            stage_target_reg <= 3'h0;
            stage_data_reg   <= 10'h000;
        end else begin
            // Any completion empties the stage, committed or not
            if (cmd_done_in) begin
                stage_valid_reg <= 1'b0;
            end else begin
                stage_valid_reg <= stage_valid_next;
            end
            stage_target_reg <= stage_target_next;
            stage_data_reg   <= stage_data_next;
        end
    end

    // ------------------------------------------------------------
    // Terminal-control registers
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            terminal_ctrl_pots_0_1_reg <= `TCON_RESET;
            terminal_ctrl_pots_2_3_reg <= `TCON_RESET;
        end else begin
            terminal_ctrl_pots_0_1_reg <= terminal_ctrl_pots_0_1_next;
            terminal_ctrl_pots_2_3_reg <= terminal_ctrl_pots_2_3_next;
        end
    end

    // ------------------------------------------------------------
    // Locks and wipers
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_reg   <= 4'hf;
            wiper_reg  <= {4{`WIPER_RESET}};
            loaded_reg <= 1'b0;
        end else begin
            if (!loaded_reg) begin
                // Caught after release; a reset may not sample ports
                lock_reg   <= nv_lock_in;
                wiper_reg  <= nv_wiper_in;
                loaded_reg <= 1'b1;
            end else begin
                wiper_reg <= wiper_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Tap decoders, one per network
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_pot
            wiper_tap_decoder #(
                .FULL_SCALE (FULL_SCALE),
                .TAPS       (TAPS)
            ) u_dec (
                .wiper_in       (wiper_reg[p*10 +: 10]),
                .tap_onehot_out (tap_onehot[p*TAPS +: TAPS])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Terminal switch drive
    // ------------------------------------------------------------
    reg [3:0] nib [0:3];
    reg [3:0] a_sw_next;
    reg [3:0] w_sw_next;
    reg [3:0] b_sw_next;
    reg [3:0] join_next;
    integer   k;

    always @* begin
        nib[0] = terminal_ctrl_pots_0_1_reg[3:0];
        nib[1] = terminal_ctrl_pots_0_1_reg[7:4];
        nib[2] = terminal_ctrl_pots_2_3_reg[3:0];
        nib[3] = terminal_ctrl_pots_2_3_reg[7:4];
        a_sw_next = 4'h0;
        w_sw_next = 4'h0;
        b_sw_next = 4'h0;
        join_next = 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            if (!nib[k][`TCON_SHDN_N_BIT]) begin
                // Stored connect bits are ignored, not overwritten
                a_sw_next[k] = 1'b0;
                w_sw_next[k] = 1'b1;
                b_sw_next[k] = 1'b1;
                join_next[k] = 1'b1;
            end else begin
                a_sw_next[k] = nib[k][`TCON_TERM_A_BIT];
                w_sw_next[k] = nib[k][`TCON_WIPER_BIT];
                b_sw_next[k] = nib[k][`TCON_TERM_B_BIT];
                join_next[k] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always @* begin
        case (rd_target_in)
            `TGT_WIPER0: rd_data_next = wiper_reg[9:0];
            `TGT_WIPER1: rd_data_next = wiper_reg[19:10];
            `TGT_WIPER2: rd_data_next = wiper_reg[29:20];
            `TGT_WIPER3: rd_data_next = wiper_reg[39:30];
            `TGT_TERM_CTRL_0_1: begin
                rd_data_next = {1'b0, 1'b1,
                                terminal_ctrl_pots_0_1_reg[7:0]};
            end
            `TGT_TERM_CTRL_2_3: begin
                rd_data_next = {1'b0, 1'b1,
                                terminal_ctrl_pots_2_3_reg[7:0]};
            end
            default: rd_data_next = 10'h000;
        endcase
    end

    // ------------------------------------------------------------
    // Registered outputs: read port
    // ------------------------------------------------------------
    // Outputs lag state by one cycle so every port leaves a flop
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out  <= 10'h000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_data_out  <= rd_data_next;
            rd_valid_out <= rd_in;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs: status and wipers
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_out <= 1'b0;
            lock_out  <= 4'hf;
            wiper_out <= {4{`WIPER_RESET}};
        end else begin
            ready_out <= loaded_reg;
            lock_out  <= lock_reg;
            wiper_out <= wiper_reg;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs: terminal-control copies
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            terminal_ctrl_pots_0_1_out <= `TCON_RESET;
            terminal_ctrl_pots_2_3_out <= `TCON_RESET;
        end else begin
            terminal_ctrl_pots_0_1_out <= terminal_ctrl_pots_0_1_reg;
            terminal_ctrl_pots_2_3_out <= terminal_ctrl_pots_2_3_reg;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs: terminal switches
    // ------------------------------------------------------------
    // Reset shows every terminal connected, as the registers do
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            term_a_sw_out <= 4'hf;
            wiper_sw_out  <= 4'hf;
            term_b_sw_out <= 4'hf;
            wb_join_out   <= 4'h0;
        end else begin
            term_a_sw_out <= a_sw_next;
            wiper_sw_out  <= w_sw_next;
            term_b_sw_out <= b_sw_next;
            wb_join_out   <= join_next;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs: tap switches
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tap_onehot_out <= {(4*TAPS){1'b0}};
        end else begin
            tap_onehot_out <= tap_onehot;
        end
    end

endmodule

// ==== design/quad_pot_map.vh ====
`ifndef QUAD_POT_MAP_VH
`define QUAD_POT_MAP_VH

// ------------------------------------------------------------
// Terminal-control register layout
// ------------------------------------------------------------
`define TCON_WIDTH        9
`define TCON_RESET        9'h1ff
`define TCON_RSVD_BIT     8
`define TCON_NIB_WIDTH    4
`define TCON_LO_NIB_LSB   0
`define TCON_HI_NIB_LSB   4
`define TCON_SHDN_N_BIT   3
`define TCON_TERM_A_BIT   2
`define TCON_WIPER_BIT    1
`define TCON_TERM_B_BIT   0

// ------------------------------------------------------------
// Command targets
// ------------------------------------------------------------
`define TGT_WIDTH         3
`define TGT_WIPER0        3'h0
`define TGT_WIPER1        3'h1
`define TGT_WIPER2        3'h2
`define TGT_WIPER3        3'h3
`define TGT_TERM_CTRL_0_1 3'h4
`define TGT_TERM_CTRL_2_3 3'h5

// ------------------------------------------------------------
// Wiper values
// ------------------------------------------------------------
`define WIPER_WIDTH       10
`define WIPER_FULL_8BIT   10'h100
`define WIPER_FULL_7BIT   10'h080
`define WIPER_RESET       10'h080

`endif

// ==== design/tcon_lock_merge.v ====
`include "quad_pot_map.vh"

module tcon_lock_merge (
    input  wire [8:0] old_in,
    input  wire [8:0] new_in,
    input  wire [1:0] lock_in,
    output wire [8:0] merged_out
);

    // ------------------------------------------------------------
    // Per-network nibble merge
    // ------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < 2; n = n + 1) begin : g_nib
            // A locked nibble keeps its stored bits
            assign merged_out[n*`TCON_NIB_WIDTH +: `TCON_NIB_WIDTH] =
                lock_in[n] ?
                old_in[n*`TCON_NIB_WIDTH +: `TCON_NIB_WIDTH] :
                new_in[n*`TCON_NIB_WIDTH +: `TCON_NIB_WIDTH];
        end
    endgenerate

    assign merged_out[`TCON_RSVD_BIT] = 1'b1;

endmodule

// ==== design/wiper_tap_decoder.v ====
`include "quad_pot_map.vh"

module wiper_tap_decoder #(
    parameter [9:0] FULL_SCALE = `WIPER_FULL_8BIT,
    parameter       TAPS       = 257
) (
    input  wire [9:0]      wiper_in,
    output wire [TAPS-1:0] tap_onehot_out
);

    // ------------------------------------------------------------
    // Clamp and decode
    // ------------------------------------------------------------
    wire [9:0] index;

    // Codes past full scale park on terminal A
    assign index = (wiper_in >= FULL_SCALE) ? FULL_SCALE : wiper_in;

    genvar t;
    generate
        for (t = 0; t < TAPS; t = t + 1) begin : g_tap
            localparam [9:0] TAP_CODE = t;
            // Tap 0 is terminal B, top tap is terminal A
            assign tap_onehot_out[t] = (index == TAP_CODE);
        end
    endgenerate

endmodule

// ==== verif/quad_pot_chk.sv ====
module quad_pot_chk #(
    parameter [9:0] FULL_SCALE = 10'h100,
    parameter       TAPS       = 257
) (
    input logic              clk_in,
    input logic              rst_n_in,
    input logic              cmd_wr_in,
    input logic [2:0]        cmd_target_in,
    input logic [9:0]        cmd_data_in,
    input logic              cmd_done_in,
    input logic              rd_in,
    input logic [2:0]        rd_target_in,
    input logic [9:0]        rd_data_out,
    input logic              rd_valid_out,
    input logic              ready_out,
    input logic [3:0]        lock_out,
    input logic [8:0]        terminal_ctrl_pots_0_1_out,
    input logic [8:0]        terminal_ctrl_pots_2_3_out,
    input logic [39:0]       wiper_out,
    input logic [3:0]        term_a_sw_out,
    input logic [3:0]        wiper_sw_out,
    input logic [3:0]        term_b_sw_out,
    input logic [3:0]        wb_join_out,
    input logic [4*TAPS-1:0] tap_onehot_out
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [8:0] t0 = terminal_ctrl_pots_0_1_out;
    wire [8:0] t1 = terminal_ctrl_pots_2_3_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ------------------------------------------------
    // Terminal and tap relations
    // ------------------------------------------------
    property p_rsvd;
        t0[8] && t1[8];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("top bit low");
    property p_shdn;
        !t0[3] |-> !term_a_sw_out[0] && wiper_sw_out[0]
            && term_b_sw_out[0] && wb_join_out[0];
    endproperty
    a_shdn: assert property (p_shdn) else $error("shutdown");
    property p_conn;
        t0[7] |-> !wb_join_out[1] && t0[6:4] ==
            {term_a_sw_out[1], wiper_sw_out[1], term_b_sw_out[1]};
    endproperty
    a_conn: assert property (p_conn) else $error("connect");
    // Locks only move at load, which ready hides
    property p_lock0;
        ready_out && $past(ready_out) && lock_out[0] |-> $stable(t0[3:0]);
    endproperty
    a_lock0: assert property (p_lock0) else $error("lock 0");
    property p_lock2;
        ready_out && $past(ready_out) && lock_out[2] |-> $stable(t1[3:0]);
    endproperty
    a_lock2: assert property (p_lock2) else $error("lock 2");
    property p_commit;
        cmd_wr_in && cmd_done_in && cmd_target_in == 3'h4 && ready_out
            && !lock_out[1] |-> ##2 t0[7:4] == $past(cmd_data_in[7:4], 2);
    endproperty
    a_commit: assert property (p_commit) else $error("commit");
    property p_change;
        $changed(t1) |-> $past(cmd_done_in, 2);
    endproperty
    a_change: assert property (p_change) else $error("early");
    property p_rd;
        rd_in && rd_target_in == 3'h5
            |=> rd_valid_out && rd_data_out == {2'b01, t1[7:0]};
    endproperty
    a_rd: assert property (p_rd) else $error("read");
    property p_zero;
        ready_out && wiper_out[9:0] == 10'h000 |-> tap_onehot_out[0];
    endproperty
    a_zero: assert property (p_zero) else $error("zero");
    property p_full;
        ready_out && wiper_out[39:30] >= FULL_SCALE
            |-> tap_onehot_out[4*TAPS-1];
    endproperty
    a_full: assert property (p_full) else $error("full");
    c_shdn: cover property (!t0[3]);
    c_lock: cover property (lock_out[0] && cmd_done_in);
    c_rd: cover property (rd_valid_out);
endmodule

bind quad_pot_terminal_control quad_pot_chk #(
    .FULL_SCALE(FULL_SCALE),
    .TAPS      (TAPS)
) chk_u (
    .clk_in, .rst_n_in, .cmd_wr_in, .cmd_target_in, .cmd_data_in,
    .cmd_done_in, .rd_in, .rd_target_in, .rd_data_out, .rd_valid_out,
    .ready_out, .lock_out, .terminal_ctrl_pots_0_1_out,
    .terminal_ctrl_pots_2_3_out, .wiper_out, .term_a_sw_out,
    .wiper_sw_out, .term_b_sw_out, .wb_join_out, .tap_onehot_out
);

// ==== verif/host_cmd_model.sv ====
module host_cmd_model (
    input  logic       clk_in,
    input  logic [9:0] rd_data_in,
    input  logic       rd_valid_in,
    output logic       cmd_wr_out,
    output logic [2:0] cmd_target_out,
    output logic [9:0] cmd_data_out,
    output logic       cmd_done_out,
    output logic       rd_out,
    output logic [2:0] rd_target_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // Command and read cycles
    // ------------------------------------------------
    initial begin
        cmd_wr_out     = 1'b0;
        cmd_target_out = 3'h0;
        cmd_data_out   = 10'h000;
        cmd_done_out   = 1'b0;
        rd_out         = 1'b0;
        rd_target_out  = 3'h0;
    end
    // Completion may ride with the write or come later alone
    task automatic send(input logic wr, input logic fin,
                        input logic [2:0] tgt, input logic [9:0] dat);
        @(posedge clk_in);
        cmd_wr_out     <= wr;
        cmd_done_out   <= fin;
        cmd_target_out <= tgt;
        cmd_data_out   <= dat;
        @(posedge clk_in);
        cmd_wr_out   <= 1'b0;
        cmd_done_out <= 1'b0;
        // Outputs trail the commit edge by one cycle
        repeat (2) @(posedge clk_in);
    endtask
    task automatic read(input logic [2:0] tgt, output logic [9:0] dat);
        @(posedge clk_in);
        rd_out        <= 1'b1;
        rd_target_out <= tgt;
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(negedge clk_in);
        dat = (rd_valid_in === 1'b1) ? rd_data_in : 10'hxxx;
        @(posedge clk_in);
    endtask
endmodule

// ==== verif/quad_pot_terminal_control_bench.sv ====
module quad_pot_terminal_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NTAPS = 257;
    localparam int NTAPS7 = 129;
    logic               clk_in           = 1'b0;
    logic               rst_n_in         = 1'b0;
    logic               write_protect_in = 1'b0;
    logic [3:0]         nv_lock_in       = 4'h0;
    logic [39:0]        nv_wiper_in      = 40'hff_d001_5400;
    logic               cmd_wr_in, cmd_done_in, rd_in;
    logic [2:0]         cmd_target_in, rd_target_in;
    logic [9:0]         cmd_data_in, rd_data_out, rd_val;
    logic               rd_valid_out, ready_out;
    logic [3:0]         lock_out, term_a_sw_out, wiper_sw_out;
    logic [3:0]         term_b_sw_out, wb_join_out, swv;
    logic [8:0]         terminal_ctrl_pots_0_1_out;
    logic [8:0]         terminal_ctrl_pots_2_3_out;
    logic [39:0]        wiper_out;
    logic [4*NTAPS-1:0] tap_onehot_out;
    logic [4*NTAPS7-1:0] tap7_out;
    logic [15:0]        pat;
    int                 fail_count   = 0;
    int                 total_checks = 0;
    int                 tidx[4]      = '{0, 85, 256, 256};
    logic [7:0]         vals[4]      = '{8'hf0, 8'had, 8'h5b, 8'h00};
    logic [9:0]         wv[5] = '{10'h080, 10'h101, 10'h0ff, 10'h100, 10'h001};
    logic [3:0]         lks[2]       = '{4'h5, 4'ha};

    always #25 clk_in = ~clk_in;

    quad_pot_terminal_control dut_u (
        .clk_in, .rst_n_in, .cmd_wr_in, .cmd_target_in, .cmd_data_in,
        .cmd_done_in, .rd_in, .rd_target_in, .write_protect_in, .nv_lock_in,
        .nv_wiper_in, .rd_data_out, .rd_valid_out, .ready_out, .lock_out,
        .terminal_ctrl_pots_0_1_out, .terminal_ctrl_pots_2_3_out,
        .wiper_out, .term_a_sw_out, .wiper_sw_out, .term_b_sw_out,
        .wb_join_out, .tap_onehot_out
    );
    // Seven-bit variant shares all stimulus
    quad_pot_terminal_control #(.EIGHT_BIT(0)) dut7_u (
        .clk_in, .rst_n_in, .cmd_wr_in, .cmd_target_in, .cmd_data_in,
        .cmd_done_in, .rd_in, .rd_target_in, .write_protect_in, .nv_lock_in,
        .nv_wiper_in, .rd_data_out(), .rd_valid_out(), .ready_out(),
        .lock_out(), .terminal_ctrl_pots_0_1_out(),
        .terminal_ctrl_pots_2_3_out(), .wiper_out(), .term_a_sw_out(),
        .wiper_sw_out(), .term_b_sw_out(), .wb_join_out(),
        .tap_onehot_out(tap7_out)
    );
    host_cmd_model host_u (
        .clk_in, .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out),
        .cmd_wr_out(cmd_wr_in), .cmd_target_out(cmd_target_in),
        .cmd_data_out(cmd_data_in), .cmd_done_out(cmd_done_in),
        .rd_out(rd_in), .rd_target_out(rd_target_in)
    );
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic check(input string what, input logic [NTAPS-1:0] seen,
                         input logic [NTAPS-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    function automatic logic [NTAPS-1:0] hot(input int i);
        return {{(NTAPS-1){1'b0}}, 1'b1} << i;
    endfunction
    // Expected {A, W, B, join}; shutdown overrides the stored bits
    function automatic logic [3:0] sw(input logic [3:0] n);
        return n[3] ? {n[2:0], 1'b0} : 4'b0111;
    endfunction
    task automatic rd_chk(input logic [2:0] tgt, input logic [9:0] exp);
        host_u.read(tgt, rd_val);
        check("read", rd_val, exp);
    endtask
    task automatic do_reset(input logic [3:0] lk);
        nv_lock_in <= lk;
        rst_n_in   <= 1'b0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial begin
        do_reset(4'h0);
        check("lock", lock_out, 4'h0);
        check("ready", ready_out, 1'b1);
        for (int p = 0; p < 4; p++) begin
            check("tap", tap_onehot_out[p*NTAPS +: NTAPS],
                  hot(tidx[p]));
        end
        rd_chk(3'h4, 10'h1ff);
        rd_chk(3'h5, 10'h1ff);
        rd_chk(3'h6, 10'h000);
        write_protect_in <= 1'b1;
        foreach (vals[k]) begin
            pat = {~vals[k], vals[k]};
            host_u.send(1'b1, 1'b1, 3'h4, {2'b00, pat[7:0]});
            host_u.send(1'b1, 1'b1, 3'h5, {2'b00, pat[15:8]});
            rd_chk(3'h4, {2'b01, pat[7:0]});
            rd_chk(3'h5, {2'b01, pat[15:8]});
            for (int p = 0; p < 4; p++) begin
                swv = {term_a_sw_out[p], wiper_sw_out[p],
                       term_b_sw_out[p], wb_join_out[p]};
                check("switch", swv,
                      sw(pat[4*p +: 4]));
            end
            check("wiper", wiper_out, nv_wiper_in);
        end
        foreach (wv[k]) begin
            host_u.send(1'b1, 1'b1, 3'h1, wv[k]);
            check("tap", tap_onehot_out[NTAPS +: NTAPS],
                  hot(wv[k] >= 10'h100 ? 256 : int'(wv[k])));
            check("tap7", tap7_out[NTAPS7 +: NTAPS7],
                  hot(wv[k] >= 10'h080 ? 128 : int'(wv[k])));
        end
        // Staged write must wait for completion
        host_u.send(1'b1, 1'b0, 3'h4, 10'h0ff);
        check("staged", terminal_ctrl_pots_0_1_out, 9'h100);
        host_u.send(1'b0, 1'b1, 3'h4, 10'h000);
        check("done", terminal_ctrl_pots_0_1_out, 9'h1ff);
        foreach (lks[i]) begin
            do_reset(lks[i]);
            check("lock", lock_out, lks[i]);
            rd_chk(3'h4, 10'h1ff);
            // Host restores its settings after every reset
            host_u.send(1'b1, 1'b1, 3'h4, 10'h000);
            host_u.send(1'b1, 1'b1, 3'h5, 10'h000);
            rd_chk(3'h4, {2'b01, {4{lks[i][1]}}, {4{lks[i][0]}}});
            rd_chk(3'h5, {2'b01, {4{lks[i][3]}}, {4{lks[i][2]}}});
            // A locked network refuses volatile wiper writes too
            host_u.send(1'b1, 1'b1, 3'h0, 10'h011);
            check("lockw", wiper_out[9:0],
                  lks[i][0] ? 10'h000 : 10'h011);
        end
        report_and_stop();
    end
endmodule
